// file: design/csic_map.svh
// Register offsets, field codes, reset values and timing figures of the clock control block
`ifndef CSIC_MAP_SVH
`define CSIC_MAP_SVH

// ****************************************************************
// Register map (byte addresses on the AXI4-Lite slave)
// ****************************************************************
`define CSIC_ADDR_W 4
`define CSIC_ADDR_CTRL 4'h0
`define CSIC_ADDR_STATUS 4'h4
`define CSIC_CTRL_W 8
`define CSIC_STAT_W 4
`define CSIC_CTRL_RST 8'h00
`define CSIC_RESP_OKAY 2'b00
`define CSIC_RESP_SLVERR 2'b10

// ****************************************************************
// Oscillator select configuration codes
// ****************************************************************
`define CSIC_OSC_RC 4'h3
`define CSIC_OSC_RC_IO 4'h4
`define CSIC_OSC_XTAL_PLL 4'h6
`define CSIC_OSC_INTIO 4'h8

// ****************************************************************
// Clock figures and times
// ****************************************************************
`define CSIC_CLK_NS 50
`define CSIC_SETTLE_NS 1000
`define CSIC_WAKE_NS 500
`define CSIC_PLL_MULT 4
`define CSIC_XTAL_MAX_HZ 10000000
`define CSIC_XTAL_PLL_MAX_HZ 40000000
`define CSIC_INT_PLL_MAX_HZ 32000000
`define CSIC_CNT_W 16
`define CSIC_SYNC_W 10

`endif

// file: design/csic_pkg.sv
// Types shared by the clock source and idle control block
package csic_pkg;

    // ****************************************************************
    // Control states and register layouts
    // ****************************************************************
    typedef enum logic [1:0] {ST_RUN, ST_IDLE, ST_WAKE} csic_state_e;

    // Control register, bit 7 down to bit 0
    typedef struct packed {
        logic pll_soft_enable;
        logic low_freq_source_select;
        logic idle_on_sleep_bit;
        logic [2:0] internal_freq_select;
        logic [1:0] sys_clk_select_bits;
    } csic_ctrl_s;

    // Status register, bit 3 down to bit 0
    typedef struct packed {
        logic cpu_running;
        logic in_idle;
        logic internal_osc_stable_flag;
        logic primary_osc_ready_flag;
    } csic_stat_s;

endpackage

// file: design/csic_top.sv
// Clock source selection, PLL steering and internal-oscillator idle control with AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
`include "csic_map.svh"

// Operation
// - RC mode drives the secondary oscillator pin with oscillator frequency divided by four.
// - RC-with-I/O mode turns that pin into bit 6 of the first port.
// - Crystal PLL mode runs crystal up to 10 MHz, multiplied by four.
// - Software PLL enable is unavailable while crystal PLL mode is configured.
// - PLL reaches the crystal only when oscillator select equals 0110.
// - With internal oscillator primary, software may enable the PLL, up to 32 MHz.
// - Internal-oscillator idle stops CPU clock, peripherals keep running.
// - Lower system clock select bit is ignored on this entry path.
// - Switching to internal multiplexer stops primary oscillator, clears its ready flag.
// - Internal oscillator output enabled when frequency select nonzero or source bit set.
// - Stable flag sets one settle interval after the output is enabled.
// - Peripheral clocks continue while the internal source settles.
// - Already-stable internal oscillator keeps its stable flag through entry.
// - All select bits clear: output disabled, stable flag clear.
// - On wake, peripherals keep clocking; CPU restarts after the wake delay.
// - Wake leaves the idle bit and system clock select bits unchanged.
// - Low-frequency oscillator runs whenever watchdog or fail-safe monitor is enabled.
// - Enabled interrupt, reset or watchdog time-out wakes the device.
// - Execution resumes on the first cycle after the wake delay.
// - Changing frequency select while internal clock is used clears the watchdog.
module csic_top #(
    parameter int SETTLE_NS = `CSIC_SETTLE_NS,
    parameter int WAKE_NS = `CSIC_WAKE_NS,
    parameter int XTAL_HZ = `CSIC_XTAL_MAX_HZ
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [`CSIC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [`CSIC_ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire logic [3:0] osc_select_config,
    input wire logic rc_osc_in,
    input wire logic primary_osc_stable,
    input wire logic wdt_timeout,
    input wire logic wdt_enable,
    input wire logic fscm_enable,
    input wire logic sleep_exec,
    input wire logic irq_wake,
    input wire logic port_a_bit6_out,
    input wire logic port_a_bit6_oe,
    output logic port_a_bit6_in,
    input wire logic secondary_osc_pin_i,
    output logic secondary_osc_pin_o,
    output logic secondary_osc_pin_oe,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic primary_osc_en,
    output logic internal_osc_en,
    output logic low_freq_osc_run,
    output logic pll_to_crystal,
    output logic pll_to_internal,
    output logic wdt_clear
);
    import csic_pkg::*;

    localparam int SETTLE_CYC = (SETTLE_NS + `CSIC_CLK_NS - 1) / `CSIC_CLK_NS;
    localparam int WAKE_CYC = (WAKE_NS + `CSIC_CLK_NS - 1) / `CSIC_CLK_NS;
    localparam logic [`CSIC_CNT_W-1:0] SETTLE_LAST = `CSIC_CNT_W'(SETTLE_CYC - 1);
    localparam logic [`CSIC_CNT_W-1:0] WAKE_LAST = `CSIC_CNT_W'(WAKE_CYC - 1);

    // Counters are 16 bits; the crystal limit holds for the PLL path
    if (SETTLE_CYC < 1 || SETTLE_CYC >= (1 << `CSIC_CNT_W) || WAKE_CYC < 1
        || WAKE_CYC >= (1 << `CSIC_CNT_W))
        $error("csic_top: settle or wake count out of range");
    if (XTAL_HZ > `CSIC_XTAL_MAX_HZ
        || XTAL_HZ * `CSIC_PLL_MULT > `CSIC_XTAL_PLL_MAX_HZ)
        $error("csic_top: crystal too fast for the PLL");

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    logic [`CSIC_SYNC_W-1:0] sync1_q;
    logic [`CSIC_SYNC_W-1:0] sync2_q;
    logic [3:0] cfg_s;
    logic rc_s;
    logic prim_stable_s;
    logic wdt_to_s;
    logic wdt_en_s;
    logic fscm_en_s;
    logic pin_s;

    // Pins and fuses all arrive from outside this clock domain
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
        end
        else
        begin
            sync1_q <= {osc_select_config, rc_osc_in, primary_osc_stable, wdt_timeout,
                        wdt_enable, fscm_enable, secondary_osc_pin_i};
            sync2_q <= sync1_q;
        end
    end

    assign {cfg_s, rc_s, prim_stable_s, wdt_to_s, wdt_en_s, fscm_en_s, pin_s} = sync2_q;

    // ****************************************************************
    // AXI4-Lite slave and control register
    // ****************************************************************
    csic_ctrl_s ctrl_q, ctrl_d;
    csic_stat_s stat;
    logic aw_full_q, aw_full_d, w_full_q, w_full_d;
    logic [`CSIC_ADDR_W-1:0] aw_addr_q, aw_addr_d;
    logic [31:0] w_data_q, w_data_d;
    logic w_strb0_q, w_strb0_d;
    logic awready_d, wready_d, bvalid_d, arready_d, rvalid_d, wdt_clear_d;
    logic [1:0] bresp_d, rresp_d;
    logic [31:0] rdata_d;
    logic is_xtal_pll;
    logic int_clock_used;
    csic_ctrl_s wr_val;

    assign is_xtal_pll = (cfg_s == `CSIC_OSC_XTAL_PLL);
    assign int_clock_used = ctrl_q.sys_clk_select_bits[1] || (cfg_s == `CSIC_OSC_INTIO);

    // Address and data are held separately, so either may arrive first
    always_comb
    begin
        wr_val = csic_ctrl_s'(w_data_q[`CSIC_CTRL_W-1:0]);
        aw_full_d = aw_full_q;
        aw_addr_d = aw_addr_q;
        w_full_d = w_full_q;
        w_data_d = w_data_q;
        w_strb0_d = w_strb0_q;
        bvalid_d = s_axi_bvalid && !s_axi_bready;
        bresp_d = s_axi_bresp;
        ctrl_d = ctrl_q;
        wdt_clear_d = 1'b0;
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_full_d = 1'b1;
            aw_addr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_full_d = 1'b1;
            w_data_d = s_axi_wdata;
            w_strb0_d = s_axi_wstrb[0];
        end
        if (aw_full_q && w_full_q && !s_axi_bvalid)
        begin
            aw_full_d = 1'b0;
            w_full_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = `CSIC_RESP_OKAY;
            if (aw_addr_q == `CSIC_ADDR_CTRL)
            begin
                if (w_strb0_q)
                begin
                    ctrl_d = wr_val;
                    if (is_xtal_pll)
                        ctrl_d.pll_soft_enable = 1'b0;
                    if (int_clock_used
                        && wr_val.internal_freq_select != ctrl_q.internal_freq_select)
                        wdt_clear_d = 1'b1;
                end
            end
            else if (aw_addr_q != `CSIC_ADDR_STATUS)
                bresp_d = `CSIC_RESP_SLVERR;
        end
        awready_d = !aw_full_d;
        wready_d = !w_full_d;
        rvalid_d = s_axi_rvalid && !s_axi_rready;
        rdata_d = s_axi_rdata;
        rresp_d = s_axi_rresp;
        if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_d = 1'b1;
            rresp_d = `CSIC_RESP_OKAY;
            rdata_d = '0;
            case (s_axi_araddr)
                `CSIC_ADDR_CTRL: rdata_d[`CSIC_CTRL_W-1:0] = ctrl_q;
                `CSIC_ADDR_STATUS: rdata_d[`CSIC_STAT_W-1:0] = stat;
                default: rresp_d = `CSIC_RESP_SLVERR;
            endcase
        end
        arready_d = !rvalid_d;
    end

    // Wake never touches the control register; only reset and a bus write do
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            ctrl_q <= csic_ctrl_s'(`CSIC_CTRL_RST);
            aw_full_q <= 1'b0;
            aw_addr_q <= '0;
            w_full_q <= 1'b0;
            w_data_q <= '0;
            w_strb0_q <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CSIC_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `CSIC_RESP_OKAY;
            wdt_clear <= 1'b0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            aw_full_q <= aw_full_d;
            aw_addr_q <= aw_addr_d;
            w_full_q <= w_full_d;
            w_data_q <= w_data_d;
            w_strb0_q <= w_strb0_d;
            s_axi_awready <= awready_d;
            s_axi_wready <= wready_d;
            s_axi_bvalid <= bvalid_d;
            s_axi_bresp <= bresp_d;
            s_axi_arready <= arready_d;
            s_axi_rvalid <= rvalid_d;
            s_axi_rdata <= rdata_d;
            s_axi_rresp <= rresp_d;
            wdt_clear <= wdt_clear_d;
        end
    end

    // ****************************************************************
    // Clock sources, idle sequencing and pin steering
    // ****************************************************************
    csic_state_e state_q, state_d;
    logic [`CSIC_CNT_W-1:0] wake_cnt_q, wake_cnt_d, settle_cnt_q, settle_cnt_d;
    logic int_stable_q, int_stable_d, prim_ready_q, prim_ready_d;
    logic [1:0] rc_cnt_q, rc_cnt_d;
    logic rc_prev_q;
    logic int_en_d, prim_en_d, cpu_en_d, lf_run_d, sec_pin_o_d, sec_pin_oe_d, port_in_d;
    logic idle_entry;
    logic wake_event;

    assign stat = '{cpu_running: cpu_clk_en, in_idle: (state_q != ST_RUN),
                    internal_osc_stable_flag: int_stable_q, primary_osc_ready_flag: prim_ready_q};
    // Lower select bit plays no part in entry
    assign idle_entry = sleep_exec && ctrl_q.idle_on_sleep_bit
                        && ctrl_q.sys_clk_select_bits[1];
    assign wake_event = irq_wake || wdt_to_s;

    always_comb
    begin
        state_d = state_q;
        wake_cnt_d = wake_cnt_q;
        case (state_q)
            ST_RUN:
                if (idle_entry)
                    state_d = ST_IDLE;
            ST_IDLE:
                if (wake_event)
                begin
                    state_d = ST_WAKE;
                    wake_cnt_d = '0;
                end
            ST_WAKE:
                if (wake_cnt_q == WAKE_LAST)
                    state_d = ST_RUN;
                else
                    wake_cnt_d = wake_cnt_q + 1'b1;
            default:
                state_d = ST_RUN;
        endcase
        cpu_en_d = (state_d == ST_RUN);
        prim_en_d = (state_d == ST_RUN) && !ctrl_q.sys_clk_select_bits[1];
        prim_ready_d = prim_en_d && primary_osc_en && prim_stable_s;
        int_en_d = (ctrl_q.internal_freq_select != '0) || ctrl_q.low_freq_source_select;
        // Settling counts up from enable; a stable source stays stable
        settle_cnt_d = settle_cnt_q;
        int_stable_d = int_stable_q;
        if (!int_en_d)
        begin
            settle_cnt_d = '0;
            int_stable_d = 1'b0;
        end
        else if (!int_stable_q)
        begin
            if (settle_cnt_q == SETTLE_LAST)
                int_stable_d = 1'b1;
            else
                settle_cnt_d = settle_cnt_q + 1'b1;
        end
        lf_run_d = wdt_en_s || fscm_en_s || ctrl_q.low_freq_source_select;
        // Count rising RC edges; bit 1 toggles every second edge
        rc_cnt_d = rc_cnt_q + {1'b0, rc_s && !rc_prev_q};
        sec_pin_o_d = rc_cnt_q[1];
        sec_pin_oe_d = (cfg_s == `CSIC_OSC_RC);
        port_in_d = 1'b0;
        if (cfg_s == `CSIC_OSC_RC_IO)
        begin
            sec_pin_o_d = port_a_bit6_out;
            sec_pin_oe_d = port_a_bit6_oe;
            port_in_d = pin_s;
        end
    end

    // Peripheral clock is never gated here, so settling never stalls it
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_q <= ST_RUN;
            wake_cnt_q <= '0;
            settle_cnt_q <= '0;
            int_stable_q <= 1'b0;
            prim_ready_q <= 1'b0;
            rc_cnt_q <= '0;
            rc_prev_q <= 1'b0;
            cpu_clk_en <= 1'b1;
            periph_clk_en <= 1'b1;
            primary_osc_en <= 1'b1;
            internal_osc_en <= 1'b0;
            low_freq_osc_run <= 1'b0;
            pll_to_crystal <= 1'b0;
            pll_to_internal <= 1'b0;
            secondary_osc_pin_o <= 1'b0;
            secondary_osc_pin_oe <= 1'b0;
            port_a_bit6_in <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            wake_cnt_q <= wake_cnt_d;
            settle_cnt_q <= settle_cnt_d;
            int_stable_q <= int_stable_d;
            prim_ready_q <= prim_ready_d;
            rc_cnt_q <= rc_cnt_d;
            rc_prev_q <= rc_s;
            cpu_clk_en <= cpu_en_d;
            periph_clk_en <= 1'b1;
            primary_osc_en <= prim_en_d;
            internal_osc_en <= int_en_d;
            low_freq_osc_run <= lf_run_d;
            pll_to_crystal <= is_xtal_pll;
            pll_to_internal <= (cfg_s == `CSIC_OSC_INTIO) && ctrl_q.pll_soft_enable;
            secondary_osc_pin_o <= sec_pin_o_d;
            secondary_osc_pin_oe <= sec_pin_oe_d;
            port_a_bit6_in <= port_in_d;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_idle_cpu_off: assert property (@(posedge clk) disable iff (reset)
        state_q == ST_IDLE |-> !cpu_clk_en && periph_clk_en)
        else $error("CPU clock running in idle");
    a_settle_periph_on: assert property (@(posedge clk) disable iff (reset)
        int_en_d && !int_stable_q |=> periph_clk_en)
        else $error("Peripheral clock lost while settling");
    a_entry_prim_off: assert property (@(posedge clk) disable iff (reset)
        state_q == ST_RUN && idle_entry |=> !primary_osc_en ##1 !prim_ready_q)
        else $error("Primary oscillator not shut down on idle entry");
    a_wake_delay_len: assert property (@(posedge clk) disable iff (reset)
        $rose(cpu_clk_en) |-> $past(state_q) == ST_WAKE && $past(wake_cnt_q) == WAKE_LAST)
        else $error("CPU restarted without the full wake delay");
    a_off_flag_clear: assert property (@(posedge clk) disable iff (reset)
        ctrl_q.internal_freq_select == '0 && !ctrl_q.low_freq_source_select
        |=> !internal_osc_en && !int_stable_q)
        else $error("Internal oscillator enabled with all selects clear");
    a_stable_flag_hold: assert property (@(posedge clk) disable iff (reset)
        int_stable_q && int_en_d |=> int_stable_q)
        else $error("Stable flag dropped while source enabled");
    a_settle_time_len: assert property (@(posedge clk) disable iff (reset)
        $rose(int_stable_q) |-> $past(settle_cnt_q) == SETTLE_LAST && $past(int_en_d))
        else $error("Stable flag set before the settle interval");
    a_lf_osc_run: assert property (@(posedge clk) disable iff (reset)
        wdt_en_s || fscm_en_s |=> low_freq_osc_run)
        else $error("Low-frequency oscillator stopped with watchdog or monitor on");
    a_idle_wake_go: assert property (@(posedge clk) disable iff (reset)
        state_q == ST_IDLE && wake_event |=> state_q == ST_WAKE && !cpu_clk_en)
        else $error("Wake event not handled");
    a_pll_soft_lock: assert property (@(posedge clk) disable iff (reset)
        is_xtal_pll && s_axi_bvalid |-> !ctrl_q.pll_soft_enable || !$past(is_xtal_pll))
        else $error("Soft PLL enable writable in crystal PLL mode");
endmodule
`default_nettype wire

// file: verification/clock_source_idle_control_test.sv
// Self-checking bench for the clock source and idle control block
`timescale 1ns/1ps
`default_nettype none
`include "csic_map.svh"
module clock_source_idle_control_test;
    import csic_pkg::*;
    localparam int SETTLE_NS = 400;
    localparam int WAKE_NS = 200;
    localparam int SC = SETTLE_NS / `CSIC_CLK_NS;
    localparam int WC = WAKE_NS / `CSIC_CLK_NS;
    logic clk, reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb, osc_select_config;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic rc_osc_in, primary_osc_stable, wdt_timeout, wdt_enable, fscm_enable, sleep_exec;
    logic irq_wake, port_a_bit6_out, port_a_bit6_oe, port_a_bit6_in, secondary_osc_pin_i;
    logic secondary_osc_pin_o, secondary_osc_pin_oe, cpu_clk_en, periph_clk_en, primary_osc_en;
    logic internal_osc_en, low_freq_osc_run, pll_to_crystal, pll_to_internal, wdt_clear;
    logic clr_seen;
    int num_errors = 0;
    int num_checks = 0;
    int cycles = 0;

    csic_top #(.SETTLE_NS(SETTLE_NS), .WAKE_NS(WAKE_NS)) i_dut (
        .clk, .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
        .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
        .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
        .s_axi_rdata, .s_axi_rresp, .osc_select_config, .rc_osc_in, .primary_osc_stable,
        .wdt_timeout, .wdt_enable, .fscm_enable, .sleep_exec, .irq_wake, .port_a_bit6_out,
        .port_a_bit6_oe, .port_a_bit6_in, .secondary_osc_pin_i, .secondary_osc_pin_o,
        .secondary_osc_pin_oe, .cpu_clk_en, .periph_clk_en, .primary_osc_en, .internal_osc_en,
        .low_freq_osc_run, .pll_to_crystal, .pll_to_internal, .wdt_clear);
    csic_osc_model i_osc (.osc_en(primary_osc_en), .pin_o(secondary_osc_pin_o),
        .pin_oe(secondary_osc_pin_oe), .rc_osc(rc_osc_in), .osc_ok(primary_osc_stable),
        .pin(secondary_osc_pin_i));

    // ****************************************************************
    // Harness
    // ****************************************************************
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Hang guard, and a latch for the one-cycle watchdog clear pulse
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (wdt_clear === 1'b1)
            clr_seen <= 1'b1;
        if (cycles == 20000)
        begin
            num_errors++;
            finish_test();
        end
    end
    task automatic finish_test;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            num_errors++;
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Write: address and data offered together, each dropped when taken
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic b;
        @(posedge clk);
        b = 1'b0;
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1'b1;
        s_axi_wdata <= {24'h0, d};
        s_axi_bready <= 1'b1;
        while (!b)
        begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
            b = s_axi_bvalid === 1'b1;
        end
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rdr(input logic [3:0] a);
        logic b;
        @(posedge clk);
        b = 1'b0;
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= a;
        s_axi_rready <= 1'b1;
        while (!b)
        begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
            b = s_axi_rvalid === 1'b1;
        end
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic sleep_pulse;
        sleep_exec <= 1'b1;
        wt(1);
        sleep_exec <= 1'b0;
        wt(2);
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_bus;
        rdr(`CSIC_ADDR_CTRL);
        chk(rd, 32'(`CSIC_CTRL_RST));
        rdr(4'h8);
        chk(32'(resp), 32'(`CSIC_RESP_SLVERR));
        wr(4'h8, 8'hff);
        chk(32'(resp), 32'(`CSIC_RESP_SLVERR));
        wr(`CSIC_ADDR_STATUS, 8'hff);
        chk(32'(resp), 32'(`CSIC_RESP_OKAY));
        rdr(`CSIC_ADDR_STATUS);
        chk(rd, 32'h9);
        rdr(`CSIC_ADDR_CTRL);
        chk(rd, 32'h0);
    endtask
    task automatic t_rc;
        int n;
        logic p;
        osc_select_config <= `CSIC_OSC_RC;
        wt(6);
        n = 0;
        p = secondary_osc_pin_o;
        // 64 cycles span eight RC periods, so four edges of the quarter clock
        repeat (64)
        begin
            @(posedge clk);
            if (secondary_osc_pin_o !== p)
                n++;
            p = secondary_osc_pin_o;
        end
        chk(32'(n >= 3 && n <= 5 && secondary_osc_pin_oe === 1'b1), 32'h1);
        osc_select_config <= `CSIC_OSC_RC_IO;
        port_a_bit6_oe <= 1'b1;
        wt(6);
        chk(32'({secondary_osc_pin_oe, secondary_osc_pin_o, port_a_bit6_in}), 32'h4);
        port_a_bit6_out <= 1'b1;
        wt(6);
        chk(32'({secondary_osc_pin_oe, secondary_osc_pin_o, port_a_bit6_in}), 32'h7);
        port_a_bit6_oe <= 1'b0;
        wt(6);
        chk(32'({secondary_osc_pin_oe, port_a_bit6_in}), 32'h1);
    endtask
    task automatic t_pll;
        osc_select_config <= `CSIC_OSC_XTAL_PLL;
        wt(5);
        wr(`CSIC_ADDR_CTRL, 8'h80);
        rdr(`CSIC_ADDR_CTRL);
        chk(rd, 32'h0);
        chk(32'({pll_to_crystal, pll_to_internal}), 32'h2);
        osc_select_config <= `CSIC_OSC_INTIO;
        wt(5);
        wr(`CSIC_ADDR_CTRL, 8'h80);
        wt(2);
        chk(32'({pll_to_crystal, pll_to_internal}), 32'h1);
    endtask
    task automatic t_int;
        clr_seen = 1'b0;
        wr(`CSIC_ADDR_CTRL, 8'h04);
        wt(1);
        chk(32'({clr_seen, internal_osc_en}), 32'h3);
        rdr(`CSIC_ADDR_STATUS);
        chk(32'(rd[1]), 32'h0);
        wt(SC);
        rdr(`CSIC_ADDR_STATUS);
        chk(32'(rd[1]), 32'h1);
        clr_seen = 1'b0;
        wr(`CSIC_ADDR_CTRL, 8'h00);
        wt(1);
        rdr(`CSIC_ADDR_STATUS);
        chk(32'({clr_seen, internal_osc_en, rd[1]}), 32'h4);
        wr(`CSIC_ADDR_CTRL, 8'h40);
        wt(SC + 2);
        chk(32'(internal_osc_en), 32'h1);
    endtask
    task automatic t_idle;
        int n;
        // Idle bit, upper select and a higher frequency; lower select set to show it is ignored
        wr(`CSIC_ADDR_CTRL, 8'h6b);
        sleep_pulse();
        chk(32'({cpu_clk_en, periph_clk_en, primary_osc_en}), 32'h2);
        rdr(`CSIC_ADDR_STATUS);
        chk(rd, 32'h6);
        irq_wake <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            irq_wake <= 1'b0;
            n++;
        end
        while (cpu_clk_en !== 1'b1 && n < 50);
        chk(32'(n >= WC + 2 && n <= WC + 3 && periph_clk_en === 1'b1), 32'h1);
        rdr(`CSIC_ADDR_CTRL);
        chk(rd, 32'h6b);
        sleep_pulse();
        chk(32'(cpu_clk_en), 32'h0);
        wdt_timeout <= 1'b1;
        wt(3);
        wdt_timeout <= 1'b0;
        wt(WC + 6);
        chk(32'(cpu_clk_en), 32'h1);
        wr(`CSIC_ADDR_CTRL, 8'h43);
        sleep_pulse();
        chk(32'(cpu_clk_en), 32'h1);
    endtask
    task automatic t_lf;
        wr(`CSIC_ADDR_CTRL, 8'h00);
        wdt_enable <= 1'b1;
        wt(5);
        chk(32'(low_freq_osc_run), 32'h1);
        wdt_enable <= 1'b0;
        fscm_enable <= 1'b1;
        wt(5);
        chk(32'(low_freq_osc_run), 32'h1);
    endtask

    // Reset for three cycles, then the scenarios in turn
    initial
    begin
        reset = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {wdt_timeout, wdt_enable, fscm_enable, sleep_exec, irq_wake, clr_seen} = 6'h0;
        {port_a_bit6_out, port_a_bit6_oe} = 2'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
        s_axi_wstrb = 4'h1;
        osc_select_config = `CSIC_OSC_RC;
        wt(3);
        reset <= 1'b0;
        wt(2);
        t_bus();
        t_rc();
        t_pll();
        t_int();
        t_idle();
        t_lf();
        finish_test();
    end
endmodule
`default_nettype wire

// file: verification/csic_osc_model.sv
// Model of the RC network, crystal and pin pull-up outside the clock block
`timescale 1ns/1ps
`default_nettype none
module csic_osc_model #(
    parameter int RC_HALF_NS = 200,
    parameter int XTAL_SETTLE_NS = 300
) (
    input wire logic osc_en,
    input wire logic pin_o,
    input wire logic pin_oe,
    output logic rc_osc,
    output logic osc_ok,
    output logic pin
);
    // RC network runs free, well below a quarter of the block clock
    initial
    begin
        rc_osc = 1'b0;
        osc_ok = 1'b0;
        forever #(RC_HALF_NS) rc_osc = ~rc_osc;
    end
    // Crystal settles a while after start and is lost at once when stopped
    always @(osc_en)
    begin
        if (osc_en !== 1'b1)
            osc_ok = 1'b0;
        else
            osc_ok <= #(XTAL_SETTLE_NS) 1'b1;
    end
    // Pull-up keeps the pin high whenever nobody drives it
    assign pin = (pin_oe === 1'b1) ? pin_o : 1'b1;
endmodule
`default_nettype wire
